// ### inc/mic_regs.svh
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH

// register byte offsets on the avalon slave
`define MIC_OFS_WAKE_FLAGS   6'h00
`define MIC_OFS_REQ_ONE      6'h04
`define MIC_OFS_REQ_TWO      6'h08
`define MIC_OFS_EN_ONE       6'h0C
`define MIC_OFS_EN_TWO       6'h10
`define MIC_OFS_EDGE_POL     6'h14
`define MIC_OFS_PFUNC_FIVE   6'h18
`define MIC_OFS_PFUNC_ONE    6'h1C
`define MIC_OFS_STATUS       6'h20

// field positions
`define MIC_EN1_WAKE_GROUP   5
`define MIC_CCR_MASK_BIT     7
`define MIC_ST_BUSY          8
`define MIC_EVEN_HI          15
`define MIC_EVEN_LO          8

// reset values
`define MIC_RST_BYTE         8'h00
`define MIC_RST_WORD         16'h0000
`define MIC_RST_PIN5         5'h00
`define MIC_RST_WAKE_PIN     8'hFF

// vector numbers
`define MIC_VEC_PIN_BASE     5'h04
`define MIC_VEC_WAKE         5'h09
`define MIC_VEC_INT_BASE     5'h0A
`define MIC_VEC_INT_LAST     5'h14

// response phases in states (system clock cycles)
`define MIC_STACK_STATES     3'h4
`define MIC_VFETCH_STATES    3'h2
`define MIC_IFETCH_STATES    3'h4
`define MIC_INTERNAL_STATES  3'h4
`define MIC_STACK_PC_STATE   3'h0
`define MIC_STACK_CCR_STATE  3'h2

// stack slot distances from the pre-exception stack pointer
`define MIC_SP_PC_SLOT       16'h0002
`define MIC_SP_CCR_SLOT      16'h0004

`endif

// ### inc/mic_pkg.sv
package mic_pkg;
   // exception sequencer phases
   typedef enum logic [2:0] {
      MIC_IDLE,
      MIC_FINISH,
      MIC_STACK,
      MIC_VFETCH,
      MIC_IFETCH,
      MIC_INTERNAL
   } mic_state_t;

   typedef logic [4:0] mic_vec_t;
   typedef logic [15:0] mic_word_t;
endpackage

// ### design/mic_core.sv
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "mic_regs.svh"

module mic_core (
   input wire logic i_clock,
   input wire logic i_rst,
   // avalon-mm slave
   input wire logic [5:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // request pins and peripheral events
   input wire logic [7:0] i_wakeup_pin_n,
   input wire logic [4:0] i_pin_request,
   input wire logic [15:0] i_periph_event,
   // cpu side
   input wire logic [7:0] i_cond_code_reg,
   input wire mic_pkg::mic_word_t i_pc,
   input wire mic_pkg::mic_word_t i_sp,
   input wire logic i_instr_done,
   input wire mic_pkg::mic_word_t i_mem_rdata,
   input wire logic i_return_from_exception,
   input wire mic_pkg::mic_word_t i_return_ccr_word,
   output logic o_hold_cpu,
   output logic o_mem_we,
   output logic o_mem_re,
   output mic_pkg::mic_word_t o_mem_addr,
   output mic_pkg::mic_word_t o_mem_wdata,
   output mic_pkg::mic_word_t o_new_sp,
   output logic o_set_mask,
   output logic o_jump,
   output mic_pkg::mic_word_t o_handler_addr,
   output mic_pkg::mic_vec_t o_vector,
   output logic [7:0] o_restored_ccr,
   output logic o_restored_ccr_valid
);
   import mic_pkg::*;

   logic [7:0] wake_flags_q, wake_func_q, wk_new, wake_set;
   logic [4:0] pin_flags_q, pin_enables_q, edge_pol_q, pin_func_q;
   logic [4:0] pr_new, pin_set;
   logic [15:0] int_flags_q, int_enables_q;
   logic wake_group_en_q;
   logic [7:0] wk_s1_q, wk_s2_q, wk_s3_q, wk_lvl_q;
   logic [4:0] pr_s1_q, pr_s2_q, pr_s3_q, pr_lvl_q;
   logic ack_q;
   logic [31:0] rdata_q;
   logic wr_go, rd_go;
   logic [31:0] rd_mux;
   mic_state_t state_q;
   logic [2:0] cnt_q;
   mic_vec_t vec_q;
   logic [7:0] ccr_q;
   mic_word_t pc_q, sp_q;
   logic any_req;
   mic_vec_t sel_vec;
   logic [15:0] int_pend;

   // word addresses always have bit zero clear
   function automatic mic_word_t word_addr(input mic_word_t a);
      word_addr = {a[15:1], 1'b0};
   endfunction

   // clear-only write: a zero bit clears, a one leaves the flag alone
   function automatic logic [15:0] w0c(input logic [15:0] cur,
                                       input logic [15:0] wd,
                                       input logic [15:0] set);
      w0c = (cur & wd) | set;
   endfunction

   // internal source index to vector, sources past ten share the last
   function automatic mic_vec_t int_vec(input logic [3:0] idx);
      if ({1'b0, idx} > (`MIC_VEC_INT_LAST - `MIC_VEC_INT_BASE)) begin
         int_vec = `MIC_VEC_INT_LAST;
      end else begin
         int_vec = `MIC_VEC_INT_BASE + {1'b0, idx};
      end
   endfunction

   // bus handshake: one wait cycle, then the access completes
   assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
   assign wr_go = i_avs_write & ack_q;
   assign rd_go = i_avs_read & ~ack_q;
   assign o_avs_readdata = rdata_q;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         wk_s1_q <= `MIC_RST_WAKE_PIN;
         wk_s2_q <= `MIC_RST_WAKE_PIN;
         wk_s3_q <= `MIC_RST_WAKE_PIN;
         pr_s1_q <= `MIC_RST_PIN5;
         pr_s2_q <= `MIC_RST_PIN5;
         pr_s3_q <= `MIC_RST_PIN5;
      end else begin
         wk_s1_q <= i_wakeup_pin_n;
         wk_s2_q <= wk_s1_q;
         wk_s3_q <= wk_s2_q;
         pr_s1_q <= i_pin_request;
         pr_s2_q <= pr_s1_q;
         pr_s3_q <= pr_s2_q;
      end
   end

   // accepted level moves only where stages two and three agree
   always_comb begin
      wk_new = (wk_s2_q & wk_s3_q) | (wk_lvl_q & (wk_s2_q ^ wk_s3_q));
      pr_new = (pr_s2_q & pr_s3_q) | (pr_lvl_q & (pr_s2_q ^ pr_s3_q));
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         wk_lvl_q <= `MIC_RST_WAKE_PIN;
         pr_lvl_q <= `MIC_RST_PIN5;
      end else begin
         wk_lvl_q <= wk_new;
         pr_lvl_q <= pr_new;
      end
   end

   // edge events compare new level with the previous one
   always_comb begin
      // falling edge on a wakeup pin
      wake_set = wake_func_q & wk_lvl_q & ~wk_new;
      // selected edge on a request pin
      pin_set = pin_func_q & ((edge_pol_q & ~pr_lvl_q & pr_new) |
                              (~edge_pol_q & pr_lvl_q & ~pr_new));
   end

   // wakeup flags
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         wake_flags_q <= `MIC_RST_BYTE;
      end else if (wr_go && i_avs_address == `MIC_OFS_WAKE_FLAGS) begin
         // zero write clears, a new edge wins
         wake_flags_q <= 8'(w0c({8'h00, wake_flags_q},
                                {8'h00, i_avs_writedata[7:0]},
                                {8'h00, wake_set}));
      end else begin
         wake_flags_q <= wake_flags_q | wake_set;
      end
   end

   // pin request flags
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         pin_flags_q <= `MIC_RST_PIN5;
      end else if (wr_go && i_avs_address == `MIC_OFS_REQ_ONE) begin
         pin_flags_q <= 5'(w0c({11'h000, pin_flags_q},
                               {11'h000, i_avs_writedata[4:0]},
                               {11'h000, pin_set}));
      end else begin
         pin_flags_q <= pin_flags_q | pin_set;
      end
   end

   // internal peripheral flags
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         int_flags_q <= `MIC_RST_WORD;
      end else if (wr_go && i_avs_address == `MIC_OFS_REQ_TWO) begin
         int_flags_q <= w0c(int_flags_q, i_avs_writedata[15:0],
                            i_periph_event);
      end else begin
         int_flags_q <= int_flags_q | i_periph_event;
      end
   end

   // control registers written by software
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         pin_enables_q <= `MIC_RST_PIN5;
         wake_group_en_q <= 1'b0;
         int_enables_q <= `MIC_RST_WORD;
         edge_pol_q <= `MIC_RST_PIN5;
         wake_func_q <= `MIC_RST_BYTE;
         pin_func_q <= `MIC_RST_PIN5;
      end else if (wr_go) begin
         case (i_avs_address)
            `MIC_OFS_EN_ONE: begin
               pin_enables_q <= i_avs_writedata[4:0];
               wake_group_en_q <= i_avs_writedata[`MIC_EN1_WAKE_GROUP];
            end
            `MIC_OFS_EN_TWO: int_enables_q <= i_avs_writedata[15:0];
            `MIC_OFS_EDGE_POL: edge_pol_q <= i_avs_writedata[4:0];
            `MIC_OFS_PFUNC_FIVE: wake_func_q <= i_avs_writedata[7:0];
            `MIC_OFS_PFUNC_ONE: pin_func_q <= i_avs_writedata[4:0];
            default: begin
            end
         endcase
      end
   end

   // read mux, unmapped reads return zero
   always_comb begin
      case (i_avs_address)
         `MIC_OFS_WAKE_FLAGS: rd_mux = {24'h000000, wake_flags_q};
         `MIC_OFS_REQ_ONE: rd_mux = {27'h0000000, pin_flags_q};
         `MIC_OFS_REQ_TWO: rd_mux = {16'h0000, int_flags_q};
         `MIC_OFS_EN_ONE: rd_mux = {26'h0000000, wake_group_en_q,
                                     pin_enables_q};
         `MIC_OFS_EN_TWO: rd_mux = {16'h0000, int_enables_q};
         `MIC_OFS_EDGE_POL: rd_mux = {27'h0000000, edge_pol_q};
         `MIC_OFS_PFUNC_FIVE: rd_mux = {24'h000000, wake_func_q};
         `MIC_OFS_PFUNC_ONE: rd_mux = {27'h0000000, pin_func_q};
         `MIC_OFS_STATUS: rd_mux = {23'h000000, (state_q != MIC_IDLE),
                                    3'h0, vec_q};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         rdata_q <= 32'h00000000;
      end else if (rd_go) begin
         rdata_q <= rd_mux;
      end
   end

   // fixed priority: pins, then wakeup group, then internal
   always_comb begin
      any_req = 1'b0;
      sel_vec = `MIC_VEC_WAKE;
      int_pend = int_flags_q & int_enables_q;
      // lowest internal index has highest priority
      for (int i = 15; i >= 0; i--) begin
         if (int_pend[i]) begin
            any_req = 1'b1;
            sel_vec = int_vec(4'(i));
         end
      end
      // group enable gates the shared wakeup vector
      if (wake_group_en_q && (wake_flags_q != `MIC_RST_BYTE)) begin
         any_req = 1'b1;
         sel_vec = `MIC_VEC_WAKE;
      end
      // pin zero highest, vectors four to eight
      for (int i = 4; i >= 0; i--) begin
         if (pin_flags_q[i] && pin_enables_q[i]) begin
            any_req = 1'b1;
            sel_vec = `MIC_VEC_PIN_BASE + 5'(i);
         end
      end
   end

   // exception sequencer
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state_q <= MIC_IDLE;
         cnt_q <= 3'h0;
         vec_q <= 5'h00;
         ccr_q <= `MIC_RST_BYTE;
         pc_q <= `MIC_RST_WORD;
         sp_q <= `MIC_RST_WORD;
      end else begin
         case (state_q)
            MIC_IDLE: begin
               // accept only while the mask flag is clear
               if (any_req && !i_cond_code_reg[`MIC_CCR_MASK_BIT]) begin
                  vec_q <= sel_vec;
                  state_q <= MIC_FINISH;
               end
            end
            MIC_FINISH: begin
               if (i_instr_done) begin
                  pc_q <= i_pc;
                  sp_q <= i_sp;
                  ccr_q <= i_cond_code_reg;
                  cnt_q <= 3'h0;
                  state_q <= MIC_STACK;
               end
            end
            MIC_STACK: begin
               if (cnt_q == `MIC_STACK_STATES - 3'h1) begin
                  cnt_q <= 3'h0;
                  state_q <= MIC_VFETCH;
               end else begin
                  cnt_q <= cnt_q + 3'h1;
               end
            end
            MIC_VFETCH: begin
               if (cnt_q == `MIC_VFETCH_STATES - 3'h1) begin
                  pc_q <= word_addr(i_mem_rdata);
                  cnt_q <= 3'h0;
                  state_q <= MIC_IFETCH;
               end else begin
                  cnt_q <= cnt_q + 3'h1;
               end
            end
            MIC_IFETCH: begin
               if (cnt_q == `MIC_IFETCH_STATES - 3'h1) begin
                  cnt_q <= 3'h0;
                  state_q <= MIC_INTERNAL;
               end else begin
                  cnt_q <= cnt_q + 3'h1;
               end
            end
            MIC_INTERNAL: begin
               if (cnt_q == `MIC_INTERNAL_STATES - 3'h1) begin
                  cnt_q <= 3'h0;
                  state_q <= MIC_IDLE;
               end else begin
                  cnt_q <= cnt_q + 3'h1;
               end
            end
            default: state_q <= MIC_IDLE;
         endcase
      end
   end

   // memory strobes for stacking and vector fetch
   always_comb begin
      o_mem_we = 1'b0;
      o_mem_re = 1'b0;
      o_mem_addr = `MIC_RST_WORD;
      o_mem_wdata = `MIC_RST_WORD;
      // return address, then condition codes as a word
      if (state_q == MIC_STACK && cnt_q == `MIC_STACK_PC_STATE) begin
         o_mem_we = 1'b1;
         o_mem_addr = word_addr(sp_q - `MIC_SP_PC_SLOT);
         o_mem_wdata = pc_q;
      end else if (state_q == MIC_STACK && cnt_q == `MIC_STACK_CCR_STATE) begin
         o_mem_we = 1'b1;
         o_mem_addr = word_addr(sp_q - `MIC_SP_CCR_SLOT);
         o_mem_wdata = {ccr_q, ccr_q};
      end else if (state_q == MIC_VFETCH) begin
         o_mem_re = 1'b1;
         o_mem_addr = word_addr({10'h000, vec_q, 1'b0});
      end
   end

   // cpu-facing controls
   assign o_hold_cpu = (state_q != MIC_IDLE) && (state_q != MIC_FINISH);
   assign o_new_sp = word_addr(sp_q - `MIC_SP_CCR_SLOT);
   // mask raised on the last stacking state
   assign o_set_mask = (state_q == MIC_STACK) &&
                       (cnt_q == `MIC_STACK_STATES - 3'h1);
   assign o_jump = (state_q == MIC_INTERNAL) &&
                   (cnt_q == `MIC_INTERNAL_STATES - 3'h1);
   assign o_handler_addr = pc_q;
   assign o_vector = vec_q;

   // even-address byte reloads the condition codes
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_restored_ccr <= `MIC_RST_BYTE;
         o_restored_ccr_valid <= 1'b0;
      end else begin
         o_restored_ccr_valid <= i_return_from_exception;
         if (i_return_from_exception) begin
            o_restored_ccr <= i_return_ccr_word[`MIC_EVEN_HI:`MIC_EVEN_LO];
         end
      end
   end
endmodule

// ### tb/mic_core_properties.sv
`timescale 1ns/10ps
module mic_core_properties (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire mic_pkg::mic_word_t i_pc,
   input wire mic_pkg::mic_word_t i_sp,
   input wire logic [7:0] i_cond_code_reg,
   input wire logic i_instr_done,
   input wire mic_pkg::mic_word_t i_mem_rdata,
   input wire logic i_return_from_exception,
   input wire mic_pkg::mic_word_t i_return_ccr_word,
   input wire logic o_hold_cpu,
   input wire logic o_mem_we,
   input wire logic o_mem_re,
   input wire mic_pkg::mic_word_t o_mem_addr,
   input wire mic_pkg::mic_word_t o_mem_wdata,
   input wire mic_pkg::mic_word_t o_new_sp,
   input wire logic o_set_mask,
   input wire logic o_jump,
   input wire mic_pkg::mic_word_t o_handler_addr,
   input wire mic_pkg::mic_vec_t o_vector,
   input wire logic [7:0] o_restored_ccr,
   input wire logic o_restored_ccr_valid
);
   import mic_pkg::*;
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (i_rst);
   // pc word, idle state, ccr byte twice in one word, then mask
   sequence s_stack;
      o_mem_we && o_mem_addr == i_sp - 16'h0002 && o_mem_wdata == i_pc
      ##1 !o_mem_we
      ##1 o_mem_we && o_mem_addr == i_sp - 16'h0004
         && o_mem_wdata == {i_cond_code_reg, i_cond_code_reg}
      ##1 o_set_mask && !o_mem_we;
   endsequence
   // two reads of the vector entry
   sequence s_fetch;
      (o_mem_re && o_mem_addr == {10'h000, o_vector, 1'h0}) [*2];
   endsequence
   // exception sequence checks
   property p_stack;
      $rose(o_hold_cpu) |-> s_stack ##1 s_fetch;
   endproperty
   a_stack: assert property (p_stack) else $error("stacking");
   property p_start;
      $rose(o_hold_cpu) |-> $past(i_instr_done);
   endproperty
   a_start: assert property (p_start) else $error("early stack");
   property p_jump;
      o_set_mask |=> (o_hold_cpu && !o_jump) [*8] ##1 !o_jump ##1 o_jump;
   endproperty
   a_jump: assert property (p_jump) else $error("jump timing");
   property p_handler;
      o_jump |-> o_handler_addr == ($past(i_mem_rdata, 8) & 16'hFFFE);
   endproperty
   a_handler: assert property (p_handler) else $error("handler");
   property p_sp;
      o_set_mask |-> o_new_sp == ((i_sp - 16'h0004) & 16'hFFFE);
   endproperty
   a_sp: assert property (p_sp) else $error("new sp");
   property p_restore;
      i_return_from_exception |=> o_restored_ccr_valid
         && {o_restored_ccr, 8'h00} == ($past(i_return_ccr_word) & 16'hFF00);
   endproperty
   a_restore: assert property (p_restore) else $error("ccr restore");
   property p_vec;
      o_jump |-> o_vector >= 5'h04 && o_vector <= 5'h14;
   endproperty
   a_vec: assert property (p_vec) else $error("vector range");
   property p_quiet;
      o_jump && i_cond_code_reg[7] |=> !o_hold_cpu [*3];
   endproperty
   a_quiet: assert property (p_quiet) else $error("masked entry");
endmodule

// ### tb/mic_cpu_model.sv
`timescale 1ns/10ps
module mic_cpu_model (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_hold,
   input wire logic i_we,
   input wire logic i_re,
   input wire mic_pkg::mic_word_t i_addr,
   input wire mic_pkg::mic_word_t i_wdata,
   input wire logic i_set_mask,
   input wire logic i_jump,
   input wire mic_pkg::mic_word_t i_handler,
   input wire mic_pkg::mic_word_t i_new_sp,
   input wire logic [7:0] i_rccr,
   input wire logic i_rccr_valid,
   input wire logic i_ret,
   input wire logic i_unmask,
   input wire logic i_slow,
   output logic [7:0] o_ccr,
   output mic_pkg::mic_word_t o_pc,
   output mic_pkg::mic_word_t o_sp,
   output logic o_done,
   output mic_pkg::mic_word_t o_rdata,
   output mic_pkg::mic_word_t o_ret_word
);
   import mic_pkg::*;
   logic [3:0] len_q;
   mic_word_t top_q;
   mic_word_t next_q;
   // one state, or thirteen when slow
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         len_q <= 4'h0;
      end else if (i_hold || o_done) begin
         len_q <= 4'h0;
      end else begin
         len_q <= len_q + 4'h1;
      end
   end
   assign o_done = !i_hold && len_q >= (i_slow ? 4'hC : 4'h0);
   // stack: last word is ccr, the one before it pc
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         top_q <= 16'h0000;
         next_q <= 16'h0000;
      end else if (i_we) begin
         top_q <= i_wdata;
         next_q <= top_q;
      end
   end
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_ccr <= 8'h80;
         o_pc <= 16'h0100;
         o_sp <= 16'h0400;
      end else begin
         if (i_set_mask) begin
            o_ccr[7] <= 1'h1;
         end else if (i_rccr_valid) begin
            o_ccr <= i_rccr;
         end else if (i_unmask) begin
            o_ccr[7] <= 1'h0;
         end
         if (i_jump) begin
            o_pc <= i_handler;
            o_sp <= i_new_sp;
         end else if (i_ret) begin
            o_pc <= next_q;
            o_sp <= o_sp + 16'h0004;
         end
      end
   end
   // odd vector entries; idle bus shows the inverse
   assign o_rdata = i_re ? {i_addr[11:0], 4'h3} : ~{i_addr[11:0], 4'h3};
   // odd byte disturbed so only the even byte may reload
   assign o_ret_word = {top_q[15:8], ~top_q[7:0]};
endmodule

// ### tb/mic_core_tb.sv
`timescale 1ns/10ps
`include "mic_regs.svh"
module mic_core_tb;
   import mic_pkg::*;
   logic i_clock = 1'h0;
   logic i_rst = 1'h1;
   logic [5:0] i_avs_address = 6'h00;
   logic i_avs_read = 1'h0;
   logic i_avs_write = 1'h0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic [7:0] i_wakeup_pin_n = 8'hFF;
   logic [4:0] i_pin_request = 5'h00;
   logic [15:0] i_periph_event = 16'h0000;
   logic i_return_from_exception = 1'h0;
   logic unmask = 1'h0;
   logic slow = 1'h0;
   logic [31:0] o_avs_readdata;
   logic [31:0] q;
   logic [7:0] i_cond_code_reg;
   logic [7:0] o_restored_ccr;
   mic_word_t i_pc, i_sp, i_mem_rdata, i_return_ccr_word;
   mic_word_t o_mem_addr, o_mem_wdata, o_new_sp, o_handler_addr;
   logic o_avs_waitrequest, i_instr_done, o_hold_cpu, o_mem_we;
   logic o_mem_re, o_set_mask, o_jump, o_restored_ccr_valid;
   mic_vec_t o_vector;
   int miscompares = 0;
   int tests_run = 0;
   // system clock
   always #4 i_clock = ~i_clock;
   mic_core u_dut (
      .i_clock, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
      .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest,
      .i_wakeup_pin_n, .i_pin_request, .i_periph_event, .i_cond_code_reg,
      .i_pc, .i_sp, .i_instr_done, .i_mem_rdata, .i_return_from_exception,
      .i_return_ccr_word, .o_hold_cpu, .o_mem_we, .o_mem_re, .o_mem_addr,
      .o_mem_wdata, .o_new_sp, .o_set_mask, .o_jump, .o_handler_addr,
      .o_vector, .o_restored_ccr, .o_restored_ccr_valid
   );
   mic_cpu_model u_cpu (
      .i_clock, .i_rst, .i_hold(o_hold_cpu), .i_we(o_mem_we),
      .i_re(o_mem_re), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
      .i_set_mask(o_set_mask), .i_jump(o_jump), .i_handler(o_handler_addr),
      .i_new_sp(o_new_sp), .i_rccr(o_restored_ccr),
      .i_rccr_valid(o_restored_ccr_valid), .i_ret(i_return_from_exception),
      .i_unmask(unmask), .i_slow(slow), .o_ccr(i_cond_code_reg),
      .o_pc(i_pc), .o_sp(i_sp), .o_done(i_instr_done),
      .o_rdata(i_mem_rdata), .o_ret_word(i_return_ccr_word)
   );
   task automatic end_sim;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // one avalon transfer, held until waitrequest is low
   task automatic bus(input logic w, input logic [5:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clock);
      i_avs_address <= a;
      i_avs_write <= w;
      i_avs_read <= !w;
      i_avs_writedata <= d;
      // waitrequest settles mid-cycle and stands to the taking edge
      do begin
         @(negedge i_clock);
         n++;
      end while (o_avs_waitrequest !== 1'h0 && n < 20);
      if (n >= 20) begin
         miscompares++;
         end_sim();
      end
      @(posedge i_clock);
      q = o_avs_readdata;
      i_avs_read <= 1'h0;
      i_avs_write <= 1'h0;
   endtask
   task automatic rdchk(input string nm, input logic [5:0] a,
         input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      check(nm, q, e);
   endtask
   // wait for the handler jump, clear the flag while masked, return
   task automatic take(input logic [5:0] a, input logic [31:0] clr,
         input mic_vec_t ev);
      int n;
      n = 0;
      do begin
         @(negedge i_clock);
         n++;
      end while (o_jump !== 1'h1 && n < 300);
      if (n >= 300) begin
         miscompares++;
         end_sim();
      end
      check("vector", {27'h0, o_vector}, {27'h0, ev});
      check("mask", {31'h0, i_cond_code_reg[7]}, 32'h1);
      bus(1'h0, a, 32'h0);
      check("kept", {31'h0, |(q & ~clr)}, 32'h1);
      bus(1'h1, a, clr);
      @(posedge i_clock);
      i_return_from_exception <= 1'h1;
      @(posedge i_clock);
      i_return_from_exception <= 1'h0;
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge i_clock);
      i_rst <= 1'h0;
      for (int k = 0; k < 10; k++) rdchk("reset", 6'(k * 4), 32'h0);
      $display("test reset done");
      bus(1'h1, `MIC_OFS_PFUNC_FIVE, 32'hFF);
      i_wakeup_pin_n <= 8'hF7;
      repeat (6) @(posedge i_clock);
      rdchk("wake set", `MIC_OFS_WAKE_FLAGS, 32'h08);
      bus(1'h1, `MIC_OFS_WAKE_FLAGS, 32'hFF);
      rdchk("one write", `MIC_OFS_WAKE_FLAGS, 32'h08);
      bus(1'h1, `MIC_OFS_WAKE_FLAGS, 32'hF7);
      rdchk("zero write", `MIC_OFS_WAKE_FLAGS, 32'h00);
      i_wakeup_pin_n <= 8'hFF;
      repeat (6) @(posedge i_clock);
      i_wakeup_pin_n <= 8'hF7;
      bus(1'h1, `MIC_OFS_PFUNC_ONE, 32'h1F);
      bus(1'h1, `MIC_OFS_EDGE_POL, 32'h05);
      i_pin_request <= 5'h1F;
      repeat (6) @(posedge i_clock);
      rdchk("rising", `MIC_OFS_REQ_ONE, 32'h05);
      i_pin_request <= 5'h00;
      repeat (6) @(posedge i_clock);
      rdchk("falling", `MIC_OFS_REQ_ONE, 32'h1F);
      i_periph_event <= 16'h8001;
      @(posedge i_clock);
      i_periph_event <= 16'h0000;
      rdchk("internal", `MIC_OFS_REQ_TWO, 32'h8001);
      $display("test flags done");
      unmask <= 1'h1;
      @(posedge i_clock);
      unmask <= 1'h0;
      repeat (30) @(posedge i_clock);
      bus(1'h0, `MIC_OFS_STATUS, 32'h0);
      check("disabled", {31'h0, q[`MIC_ST_BUSY]}, 32'h0);
      bus(1'h1, `MIC_OFS_EN_ONE, 32'h3F);
      bus(1'h1, `MIC_OFS_EN_TWO, 32'hFFFF);
      for (int k = 0; k < 5; k++) begin
         take(`MIC_OFS_REQ_ONE, ~(32'h1 << k),
              `MIC_VEC_PIN_BASE + 5'(k));
      end
      take(`MIC_OFS_WAKE_FLAGS, 32'hF7, `MIC_VEC_WAKE);
      slow <= 1'h1;
      take(`MIC_OFS_REQ_TWO, 32'hFFFE, `MIC_VEC_INT_BASE);
      take(`MIC_OFS_REQ_TWO, 32'h7FFF, `MIC_VEC_INT_LAST);
      $display("test accept done");
      repeat (4) @(posedge i_clock);
      fork
         bus(1'h1, `MIC_OFS_REQ_TWO, 32'hFFFD);
         begin
            repeat (2) @(posedge i_clock);
            i_periph_event <= 16'h0002;
            @(posedge i_clock);
            i_periph_event <= 16'h0000;
         end
      join
      take(`MIC_OFS_REQ_TWO, 32'hFFFD, `MIC_VEC_INT_BASE + 5'h01);
      $display("test collision done");
      end_sim();
   end
   // watchdog
   initial begin
      #100000;
      miscompares++;
      end_sim();
   end
endmodule
bind mic_core mic_core_properties u_props (
   .i_clock, .i_rst, .i_pc, .i_sp, .i_cond_code_reg, .i_instr_done,
   .i_mem_rdata, .i_return_from_exception, .i_return_ccr_word, .o_hold_cpu,
   .o_mem_we, .o_mem_re, .o_mem_addr, .o_mem_wdata, .o_new_sp, .o_set_mask,
   .o_jump, .o_handler_addr, .o_vector, .o_restored_ccr,
   .o_restored_ccr_valid
);
